// [rtl/tdr_tx_ring.sv]
`timescale 1ns/10ps
// How it works
// - write status back only when report requested
// - done bit zero, after processing or send
// - late collision bit two, window by speed
// - excess collision bit one beyond threshold
// - options taken from first descriptor only
// - layer-4 checksum insert follows option bit
// - IP checksum insert follows option bit
// - tag inserted when global and end-of-packet descriptor enable
// - special field used only with insert, end
// - special splits priority, canonical bit, identifier
// - process from head, stop when head equals tail
// - base is 64 bits, low four ignored
// - length low seven bits read zero
// - descriptor address is base plus sixteen index
// - indices address up to 64K descriptors
// - head read reflects data already loaded
// - once enabled fetch descriptor at head
// - status write completes before head increments
// - head advances after data stored in FIFO
// - queue-empty cause raised when head meets tail
// - report status once data buffer fetched
module tdr_tx_ring (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // host memory port
  output logic memReq,
  output logic memWe,
  output logic [63:0] memAddr,
  output logic [3:0] memBe,
  output logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic [tdr_pkg::DESC_W-1:0] memRdata,
  // packet data loader
  output logic dmaReq,
  output logic [63:0] dmaAddr,
  output logic [15:0] dmaLen,
  output logic dmaEop,
  output logic ipCsumInsert,
  output logic l4CsumInsert,
  output logic tagInsert,
  output logic [2:0] tagUserLevel,
  output logic canonicalFormBit,
  output logic [11:0] tagVlanId,
  output logic [15:0] vlanType,
  input wire logic dmaAck,
  // mac results
  input wire logic txDone,
  input wire logic colPulse,
  input wire logic [15:0] txByteCount,
  output logic queueEmptyCause
);
  typedef struct packed {
    tdr_pkg::tdr_state_e st;
    logic [31:0] baseLo;
    logic [31:0] baseHi;
    logic [tdr_pkg::LEN_W-1:0] lenBytes;
    logic [tdr_pkg::IDX_W-1:0] head;
    logic [tdr_pkg::IDX_W-1:0] tail;
    logic [15:0] ctrl;
    logic [15:0] vlanType;
    logic qEmpty;
    logic [31:0] rdData;
    logic [7:0] cmd;
    logic [15:0] special;
    logic firstDesc;
    logic ipCs;
    logic l4Cs;
    logic tagIns;
    logic [3:0] tx_completion_bits;
    logic memReq;
    logic memWe;
    logic [63:0] memAddr;
    logic [31:0] memWdata;
    logic dmaReq;
    logic [63:0] dmaAddr;
    logic [15:0] dmaLen;
  } tdr_ring_s;

  tdr_ring_s r;
  tdr_ring_s next_r;
  logic [tdr_pkg::IDX_W:0] slots;
  logic [tdr_pkg::IDX_W:0] headInc;
  logic [tdr_pkg::IDX_W-1:0] headNext;
  logic [63:0] descAddr;
  logic collClear;
  logic lateColl;
  logic excessColl;
  logic halfDup;
  logic waitForWire;
  logic [7:0] fetchCmd;
  logic [7:0] fetchOpts;
  logic fetchEop;
  logic fetchTagReq;

  // ****************************************************************
  // ring arithmetic
  // ****************************************************************
  assign slots = r.lenBytes[tdr_pkg::LEN_W-1:tdr_pkg::DESC_SHIFT];
  assign headInc = {1'b0, r.head} + 1'b1;
  assign headNext = (headInc >= slots) ? '0 : headInc[tdr_pkg::IDX_W-1:0];
  assign descAddr = {r.baseHi, r.baseLo[31:tdr_pkg::BASE_ALIGN], {tdr_pkg::BASE_ALIGN{1'b0}}}
    + 64'({r.head, {tdr_pkg::DESC_SHIFT{1'b0}}});
  assign halfDup = r.ctrl[tdr_pkg::CTRL_HALF_DUP];
  assign collClear = (r.st == tdr_pkg::ST_LOAD) && dmaAck;
  // report-sent holds the head until the frame has left the wire
  assign waitForWire = r.ctrl[tdr_pkg::CTRL_RPS_MODE] && r.cmd[tdr_pkg::CMD_RPS]
    && r.cmd[tdr_pkg::CMD_EOP];

  // ****************************************************************
  // fields of the descriptor on the memory read bus
  // ****************************************************************
  assign fetchCmd = memRdata[tdr_pkg::D_CMD_LSB +: 8];
  assign fetchOpts = memRdata[tdr_pkg::D_PACKET_OPTIONS_LSB +: 8];
  assign fetchEop = fetchCmd[tdr_pkg::CMD_EOP];
  assign fetchTagReq = fetchCmd[tdr_pkg::CMD_VLE];

  // ****************************************************************
  // collision monitor for the packet on the wire
  // ****************************************************************
  tdr_coll_mon u_coll (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .clear(collClear),
    .halfDuplex(halfDup),
    .gigSpeed(r.ctrl[tdr_pkg::CTRL_GIG]),
    .threshold(r.ctrl[tdr_pkg::CTRL_CT_LSB +: tdr_pkg::CT_W]),
    .colPulse(colPulse),
    .byteCount(txByteCount),
    .lateColl(lateColl),
    .excessColl(excessColl)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_r = r;

    // register reads: data stands in the cycle after the strobe
    next_r.rdData = '0;
    if (regRd) begin
      unique case (regAddr)
        tdr_pkg::REG_BASE_LO: begin
          next_r.rdData = r.baseLo;
        end
        tdr_pkg::REG_BASE_HI: begin
          next_r.rdData = r.baseHi;
        end
        tdr_pkg::REG_LENGTH: begin
          next_r.rdData = 32'(r.lenBytes);
        end
        tdr_pkg::REG_HEAD: begin
          next_r.rdData = 32'(r.head);
        end
        tdr_pkg::REG_TAIL: begin
          next_r.rdData = 32'(r.tail);
        end
        tdr_pkg::REG_CTRL: begin
          next_r.rdData = 32'(r.ctrl);
        end
        tdr_pkg::REG_CAUSE: begin
          next_r.rdData = 32'(r.qEmpty);
        end
        tdr_pkg::REG_VLAN_TYPE: begin
          next_r.rdData = 32'(r.vlanType);
        end
        default: begin
          next_r.rdData = '0;
        end
      endcase
    end

    // register writes
    if (regWr) begin
      unique case (regAddr)
        tdr_pkg::REG_BASE_LO: begin
          next_r.baseLo = {regWdata[31:tdr_pkg::BASE_ALIGN], {tdr_pkg::BASE_ALIGN{1'b0}}};
        end
        tdr_pkg::REG_BASE_HI: begin
          next_r.baseHi = regWdata;
        end
        tdr_pkg::REG_LENGTH: begin
          next_r.lenBytes = {regWdata[tdr_pkg::LEN_W-1:tdr_pkg::LEN_ALIGN],
            {tdr_pkg::LEN_ALIGN{1'b0}}};
        end
        tdr_pkg::REG_HEAD: begin
          // moving head under a running engine would corrupt the ring
          if (r.st == tdr_pkg::ST_IDLE) begin
            next_r.head = regWdata[tdr_pkg::IDX_W-1:0];
          end
        end
        tdr_pkg::REG_TAIL: begin
          next_r.tail = regWdata[tdr_pkg::IDX_W-1:0];
        end
        tdr_pkg::REG_CTRL: begin
          next_r.ctrl = regWdata[15:0];
        end
        tdr_pkg::REG_CAUSE: begin
          if (regWdata[tdr_pkg::CAUSE_QE]) begin
            next_r.qEmpty = 1'b0;
          end
        end
        tdr_pkg::REG_VLAN_TYPE: begin
          next_r.vlanType = regWdata[15:0];
        end
        default: begin
        end
      endcase
    end

    // descriptor engine
    unique case (r.st)
      tdr_pkg::ST_IDLE: begin
        // a ring of zero length never starts, whatever head and tail say
        if (r.ctrl[tdr_pkg::CTRL_TX_EN] && r.head != r.tail && slots != '0) begin
          next_r.memReq = 1'b1;
          next_r.memWe = 1'b0;
          next_r.memAddr = descAddr;
          next_r.st = tdr_pkg::ST_FETCH;
        end
      end
      tdr_pkg::ST_FETCH: begin
        if (memAck) begin
          next_r.memReq = 1'b0;
          next_r.cmd = fetchCmd;
          next_r.special = memRdata[tdr_pkg::D_SPEC_LSB +: 16];
          if (r.firstDesc) begin
            // reserved option bits are simply not looked at
            next_r.ipCs = fetchOpts[tdr_pkg::PACKET_OPTIONS_IP_CHECKSUM_INSERT];
            next_r.l4Cs = fetchOpts[tdr_pkg::PACKET_OPTIONS_L4_CHECKSUM_INSERT];
          end
          // the descriptor after an end of packet opens the next packet
          next_r.firstDesc = fetchEop;
          next_r.tagIns = r.ctrl[tdr_pkg::CTRL_TAG_MODE] && fetchTagReq
            && fetchEop;
          next_r.dmaReq = 1'b1;
          next_r.dmaAddr = memRdata[tdr_pkg::D_BUF_LSB +: 64];
          next_r.dmaLen = memRdata[tdr_pkg::D_LEN_LSB +: 16];
          next_r.tx_completion_bits = '0;
          next_r.st = tdr_pkg::ST_LOAD;
        end
      end
      tdr_pkg::ST_LOAD: begin
        if (dmaAck) begin
          next_r.dmaReq = 1'b0;
          if (waitForWire) begin
            next_r.st = tdr_pkg::ST_WAITTX;
          end else if (r.cmd[tdr_pkg::CMD_RS]) begin
            next_r.tx_completion_bits[tdr_pkg::STA_DD] = 1'b1;
            next_r.memReq = 1'b1;
            next_r.memWe = 1'b1;
            next_r.memAddr = descAddr + tdr_pkg::STA_BYTE_OFS;
            next_r.memWdata = 32'(next_r.tx_completion_bits);
            next_r.st = tdr_pkg::ST_WBACK;
          end else begin
            next_r.st = tdr_pkg::ST_ADV;
          end
        end
      end
      tdr_pkg::ST_WAITTX: begin
        // head holds here until the frame has left or was abandoned
        if (txDone) begin
          next_r.tx_completion_bits[tdr_pkg::STA_DD] = 1'b1;
          next_r.tx_completion_bits[tdr_pkg::STA_EC] = excessColl;
          next_r.tx_completion_bits[tdr_pkg::STA_LC] = lateColl;
          next_r.memReq = 1'b1;
          next_r.memWe = 1'b1;
          next_r.memAddr = descAddr + tdr_pkg::STA_BYTE_OFS;
          next_r.memWdata = 32'(next_r.tx_completion_bits);
          next_r.st = tdr_pkg::ST_WBACK;
        end
      end
      tdr_pkg::ST_WBACK: begin
        if (memAck) begin
          next_r.memReq = 1'b0;
          next_r.memWe = 1'b0;
          next_r.st = tdr_pkg::ST_ADV;
        end
      end
      tdr_pkg::ST_ADV: begin
        next_r.head = headNext;
        // sticky; an engine set beats a software clear in the same cycle
        if (headNext == r.tail) begin
          next_r.qEmpty = 1'b1;
        end
        next_r.st = tdr_pkg::ST_IDLE;
      end
      default: begin
        next_r.st = tdr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= tdr_pkg::ST_IDLE;
      r.ctrl <= tdr_pkg::CTRL_RST;
      r.vlanType <= tdr_pkg::VLAN_TYPE_RST;
      r.firstDesc <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign regRdata = r.rdData;
  assign memReq = r.memReq;
  assign memWe = r.memWe;
  assign memAddr = r.memAddr;
  // write-back touches only the status byte, never the host's fields
  assign memBe = r.memWe ? tdr_pkg::STA_BYTE_EN : '1;
  assign memWdata = r.memWdata;
  assign dmaReq = r.dmaReq;
  assign dmaAddr = r.dmaAddr;
  assign dmaLen = r.dmaLen;
  assign dmaEop = r.cmd[tdr_pkg::CMD_EOP];
  assign ipCsumInsert = r.ipCs;
  assign l4CsumInsert = r.l4Cs;
  assign tagInsert = r.tagIns;
  // fields are zero unless the tag is really inserted
  assign tagUserLevel = r.tagIns ? r.special[tdr_pkg::SPEC_PRI_LSB +: 3] : '0;
  assign canonicalFormBit = r.tagIns & r.special[tdr_pkg::SPEC_CFI];
  assign tagVlanId = r.tagIns ? r.special[tdr_pkg::SPEC_VID_LSB +: 12] : '0;
  assign vlanType = r.vlanType;
  assign queueEmptyCause = r.qEmpty;
endmodule

// [inc/tdr_pkg.sv]
package tdr_pkg;
  // ****************************************************************
  // register map, byte addresses on the plain register port
  // ****************************************************************
  localparam logic [7:0] REG_BASE_LO = 8'h00;
  localparam logic [7:0] REG_BASE_HI = 8'h04;
  localparam logic [7:0] REG_LENGTH = 8'h08;
  localparam logic [7:0] REG_HEAD = 8'h0c;
  localparam logic [7:0] REG_TAIL = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam logic [7:0] REG_CAUSE = 8'h18;
  localparam logic [7:0] REG_VLAN_TYPE = 8'h1c;

  // ****************************************************************
  // control register fields and reset values
  // ****************************************************************
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_TAG_MODE = 1;
  localparam int CTRL_HALF_DUP = 2;
  localparam int CTRL_GIG = 3;
  localparam int CTRL_RPS_MODE = 4;
  localparam int CTRL_CT_LSB = 8;
  localparam int CT_W = 8;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] VLAN_TYPE_RST = 16'h8100;
  localparam int CAUSE_QE = 0;

  // ****************************************************************
  // ring geometry
  // ****************************************************************
  localparam int IDX_W = 16;
  localparam int LEN_W = 21;
  localparam int BASE_ALIGN = 4;
  localparam int LEN_ALIGN = 7;
  localparam int DESC_SHIFT = 4;
  localparam logic [63:0] STA_BYTE_OFS = 64'h0000_0000_0000_000c;
  localparam logic [3:0] STA_BYTE_EN = 4'h1;

  // ****************************************************************
  // descriptor layout, 128 bits
  // ****************************************************************
  localparam int DESC_W = 128;
  localparam int D_BUF_LSB = 0;
  localparam int D_LEN_LSB = 64;
  localparam int D_CMD_LSB = 88;
  localparam int D_PACKET_OPTIONS_LSB = 104;
  localparam int D_SPEC_LSB = 112;
  localparam int CMD_EOP = 0;
  localparam int CMD_RS = 3;
  localparam int CMD_RPS = 4;
  localparam int CMD_VLE = 6;
  localparam int PACKET_OPTIONS_IP_CHECKSUM_INSERT = 0;
  localparam int PACKET_OPTIONS_L4_CHECKSUM_INSERT = 1;
  localparam int STA_DD = 0;
  localparam int STA_EC = 1;
  localparam int STA_LC = 2;
  localparam int SPEC_PRI_LSB = 13;
  localparam int SPEC_CFI = 12;
  localparam int SPEC_VID_LSB = 0;

  // ****************************************************************
  // collision windows in bytes
  // ****************************************************************
  localparam logic [15:0] COLL_WIN_SLOW = 16'h0040;
  localparam logic [15:0] COLL_WIN_GIG = 16'h0200;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_LOAD = 3'b010,
    ST_WAITTX = 3'b011,
    ST_WBACK = 3'b100,
    ST_ADV = 3'b101
  } tdr_state_e;
endpackage

// [rtl/tdr_coll_mon.sv]
`timescale 1ns/10ps
module tdr_coll_mon (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic halfDuplex,
  input wire logic gigSpeed,
  input wire logic [tdr_pkg::CT_W-1:0] threshold,
  input wire logic colPulse,
  input wire logic [15:0] byteCount,
  output logic lateColl,
  output logic excessColl
);
  typedef struct packed {
    logic [tdr_pkg::CT_W:0] count;
    logic late;
    logic excess;
  } tdr_coll_s;

  tdr_coll_s r;
  tdr_coll_s next_r;
  logic [15:0] window;

  always_comb begin
    next_r = r;
    window = gigSpeed ? tdr_pkg::COLL_WIN_GIG : tdr_pkg::COLL_WIN_SLOW;
    if (clear) begin
      next_r = '0;
    end else if (colPulse && halfDuplex) begin
      // counter saturates so a storm cannot wrap it back under the limit
      if (!(&r.count)) begin
        next_r.count = r.count + 1'b1;
      end
      if (byteCount >= window) begin
        next_r.late = 1'b1;
      end
      if (r.count >= {1'b0, threshold}) begin
        next_r.excess = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // full duplex has no collisions, so both flags read as zero there
  assign lateColl = r.late & halfDuplex;
  assign excessColl = r.excess & halfDuplex;
endmodule

// [tb/tdr_tx_ring_asserts.sv]
`timescale 1ns/10ps
module tdr_tx_ring_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [63:0] memAddr,
  input wire logic [3:0] memBe,
  input wire logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic dmaReq,
  input wire logic [63:0] dmaAddr,
  input wire logic dmaAck,
  input wire logic tagInsert,
  input wire logic [2:0] tagUserLevel,
  input wire logic canonicalFormBit,
  input wire logic [11:0] tagVlanId,
  input wire logic queueEmptyCause
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  mem_hold_a: assert property (
    memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
    else $error("memory request changed before ack");
  mem_drop_a: assert property (memReq && memAck |=> !memReq)
    else $error("memory request kept after ack");
  desc_read_a: assert property (
    memReq && !memWe |-> memBe == 4'hf && memAddr[3:0] == 4'h0)
    else $error("descriptor read misaligned");
  sta_write_a: assert property (
    memReq && memWe |-> memBe == 4'h1 && memAddr[3:0] == 4'hc && memWdata[0])
    else $error("status write malformed");
  one_req_a: assert property (!(memReq && dmaReq))
    else $error("memory and data requests overlap");
  load_after_a: assert property (memReq && !memWe && memAck |=> dmaReq)
    else $error("data load not started after fetch");
  dma_hold_a: assert property (
    dmaReq && !dmaAck |=> dmaReq && $stable(dmaAddr))
    else $error("data request changed before ack");
  tag_zero_a: assert property (
    !tagInsert |-> {tagUserLevel, canonicalFormBit, tagVlanId} == 16'h0)
    else $error("tag fields set without insert");
  rdata_idle_a: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside read slot");
  qe_sticky_a: assert property (
    queueEmptyCause && !(regWr && regAddr == 8'h18 && regWdata[0]) |=> queueEmptyCause)
    else $error("queue empty cause lost");
  cover property (memReq && memWe && memAck);
  cover property (dmaReq && dmaAck && tagInsert);
  cover property ($rose(queueEmptyCause));
endmodule
bind tdr_tx_ring tdr_tx_ring_asserts i_chk (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .memReq(memReq),
  .memWe(memWe), .memAddr(memAddr), .memBe(memBe), .memWdata(memWdata), .memAck(memAck),
  .dmaReq(dmaReq), .dmaAddr(dmaAddr), .dmaAck(dmaAck), .tagInsert(tagInsert),
  .tagUserLevel(tagUserLevel), .canonicalFormBit(canonicalFormBit), .tagVlanId(tagVlanId),
  .queueEmptyCause(queueEmptyCause));

// [tb/tdr_host_mem.sv]
`timescale 1ns/10ps
module tdr_host_mem (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [63:0] base,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [63:0] memAddr,
  input wire logic [3:0] memBe,
  input wire logic [31:0] memWdata,
  output logic memAck,
  output logic [tdr_pkg::DESC_W-1:0] memRdata,
  input wire logic dmaReq,
  output logic dmaAck
);
  logic [127:0] desc [8];
  logic [7:0] tx_completion_bits [8];
  logic [2:0] idx;
  int mseed = 10;
  assign idx = memAddr[6:4] - base[6:4];
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memAck <= 1'b0;
      dmaAck <= 1'b0;
      memRdata <= '0;
    end else begin
      // random ack delay: prompt and slow answers both occur
      memAck <= memReq && !memAck && (($random(mseed) & 3) != 0);
      dmaAck <= dmaReq && !dmaAck && (($random(mseed) & 7) != 0);
      // no stale data between reads
      memRdata <= (memReq && !memWe) ? desc[idx] : ~memRdata;
      // only the status byte lands in memory
      if (memReq && memAck && memWe && memBe[0]) tx_completion_bits[idx] <= memWdata[7:0];
    end
  end
endmodule

// [tb/tdr_tx_ring_tb.sv]
`timescale 1ns/10ps
module tdr_tx_ring_tb;
  logic clk = 0, arst_n = 0, regWr = 0, regRd = 0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, memWdata;
  logic memReq, memWe, memAck, dmaReq, dmaEop, dmaAck;
  logic [63:0] memAddr, dmaAddr, base = 64'h0;
  logic [3:0] memBe;
  logic [127:0] memRdata, cur, d;
  logic [15:0] dmaLen, vlanType, ctrl, txByteCount = 16'h0;
  logic ipCsumInsert, l4CsumInsert, tagInsert, canonicalFormBit, queueEmptyCause;
  logic [2:0] tagUserLevel, sh = 3'h0, eh = 3'h0, ci, st, tl;
  logic [11:0] tagVlanId;
  logic txDone = 0, colPulse = 0, prevDma = 0, first = 1;
  logic [1:0] fo;
  logic [7:0] es [5];
  int seed = 10, fail_count = 0, comparisons = 0, n, p;
  localparam logic [15:0] CT [4] = '{16'h0003, 16'h0001, 16'h0415, 16'h001d};
  localparam logic [15:0] CB [4] = '{16'h0064, 16'h0064, 16'h0064, 16'h012c};
  wire [19:0] dmaOpts = {dmaEop, ipCsumInsert, l4CsumInsert, tagInsert, tagUserLevel,
    canonicalFormBit, tagVlanId};
  always #2.5 clk = ~clk;
  tdr_tx_ring i_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memBe(memBe), .memWdata(memWdata),
    .memAck(memAck), .memRdata(memRdata), .dmaReq(dmaReq), .dmaAddr(dmaAddr),
    .dmaLen(dmaLen), .dmaEop(dmaEop), .ipCsumInsert(ipCsumInsert),
    .l4CsumInsert(l4CsumInsert), .tagInsert(tagInsert), .tagUserLevel(tagUserLevel),
    .canonicalFormBit(canonicalFormBit), .tagVlanId(tagVlanId), .vlanType(vlanType),
    .dmaAck(dmaAck), .txDone(txDone), .colPulse(colPulse), .txByteCount(txByteCount),
    .queueEmptyCause(queueEmptyCause));
  tdr_host_mem i_mem (.clk(clk), .arst_n(arst_n), .base(base), .memReq(memReq),
    .memWe(memWe), .memAddr(memAddr), .memBe(memBe), .memWdata(memWdata),
    .memAck(memAck), .memRdata(memRdata), .dmaReq(dmaReq), .dmaAck(dmaAck));
  // ****************************************************************
  // mac stand-in: one collision, then frame end, after each load
  // ****************************************************************
  always @(posedge clk) begin
    sh <= {sh[1:0], dmaAck};
    colPulse <= sh[0];
    txDone <= sh[2];
  end
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(regRdata, e);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // collision flags only reach memory on a report-sent write in half duplex
  function automatic logic [7:0] exp_sta(logic [15:0] c, logic [127:0] x, logic [15:0] b);
    logic w;
    w = c[4] & x[92] & x[88];
    if (!(x[91] | w)) return 8'hf0;
    if (!(w & c[2])) return 8'h01;
    return {5'h0, b >= (c[3] ? 16'h0200 : 16'h0040), c[15:8] == 8'h0, 1'b1};
  endfunction
  function automatic logic [19:0] exp_opt(logic [127:0] x, logic [1:0] o, logic tm);
    logic t;
    t = tm & x[94] & x[88];
    return {x[88], o, t, t ? x[127:112] : 16'h0};
  endfunction
  always @(negedge clk) begin
    if (memReq && memAck && !memWe) begin
      chk(memAddr, base + {eh, 4'h0});
      cur = memRdata;
      ci = eh;
      eh = eh + 3'h1;
    end
    if (memReq && memAck && memWe) chk(memAddr, base + {ci, 4'hc});
    if (dmaReq && !prevDma) begin
      if (first) fo = {cur[104], cur[105]};
      first = cur[88];
      chk({dmaAddr, dmaLen}, {cur[63:0], cur[79:64]});
      chk(dmaOpts, exp_opt(cur, fo, ctrl[1]));
    end
    prevDma = dmaReq;
  end
  initial begin
    ctrl = 16'h0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (n = 0; n <= 32; n += 4) rd(8'(n), (n == 28) ? 32'h8100 : 32'h0);
    chk(vlanType, 16'h8100);
    base = {$random(seed), $random(seed)};
    wr(8'h00, base[31:0]);
    wr(8'h04, base[63:32]);
    base[3:0] = 4'h0;
    rd(8'h00, base[31:0]);
    rd(8'h04, base[63:32]);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h001f_ff80);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_ffff);
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h0000_00a5);
    rd(8'h08, 32'h0000_0080);
    $display("register checks done");
    for (p = 0; p < 4; p++) begin
      st = eh;
      for (n = 0; n < 5; n++) begin
        d = {$random(seed), $random(seed), $random(seed), $random(seed)};
        d[111:106] = 6'h0;
        if (n == 4) d[88] = 1'b1;
        d[92] = d[92] & d[88];
        es[n] = exp_sta(CT[p], d, CB[p]);
        i_mem.desc[3'(st + n)] = d;
        i_mem.tx_completion_bits[3'(st + n)] = 8'hf0;
      end
      tl = st + 3'h5;
      ctrl = CT[p];
      wr(8'h14, {16'h0, ctrl});
      txByteCount <= CB[p];
      wr(8'h10, {29'h0, tl});
      for (n = 0; n < 3000 && queueEmptyCause !== 1'b1; n++) @(negedge clk);
      if (n == 3000) begin
        fail_count++;
        test_done;
      end
      rd(8'h0c, {29'h0, tl});
      for (n = 0; n < 5; n++) chk(i_mem.tx_completion_bits[3'(st + n)], es[n]);
      rd(8'h18, 32'h1);
      wr(8'h18, 32'h1);
      rd(8'h18, 32'h0);
      $display("ring pass %0d done", p);
    end
    test_done;
  end
endmodule
